// ### core/lsi_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsi_cfg.svh"

module lsi_irq #(
	parameter int PERIOD_CYC = `LSI_PERIOD_CYC
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic REG_WR,
	input wire logic REG_WORD,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic CMD_STB,
	input wire logic [1:0] CMD_TXN,
	input wire logic ADC_EN,
	input wire logic [15:0] CH0_DATA,
	output logic INTEG_ACTIVE,
	output logic INTEG_DONE,
	output logic INT_N_O,
	output logic INT_N_OE
);

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] integration_cycles_field_q, integration_cycles_field_d;
	lsi_pkg::lsi_ctl_t ctl_q, ctl_d;
	lsi_pkg::lsi_thresh_t thr_q, thr_d;
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic valid_q, valid_d;
	// Control byte as it would land, split out because a call result cannot be bit-selected
	logic [7:0] ctl_byte;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		hit = REG_WR && ((a == base) || (REG_WORD && (a + 8'h01 == base)));
	endfunction : hit

	function automatic logic [7:0] pick(input logic [7:0] a, input logic [7:0] base);
		pick = (a == base) ? REG_WDATA[7:0] : REG_WDATA[15:8];
	endfunction : pick

	always_comb begin
		ctl_byte = pick(REG_ADDR, `LSI_ADDR_IRQ_MODE_SELECT);
		integration_cycles_field_d = integration_cycles_field_q;
		ctl_d = ctl_q;
		thr_d = thr_q;
		if (hit(REG_ADDR, `LSI_ADDR_TIMING)) begin
			integration_cycles_field_d = pick(REG_ADDR, `LSI_ADDR_TIMING);
		end
		if (hit(REG_ADDR, `LSI_ADDR_IRQ_MODE_SELECT)) begin
			ctl_d.halt_on_irq = ctl_byte[`LSI_HALT_BIT];
			ctl_d.irq_mode_select = ctl_byte[`LSI_MODE_BIT];
			ctl_d.persist = ctl_byte[`LSI_PERSIST_MSB:0];
		end
		// Thresholds are meant for word writes so both bytes land together
		if (hit(REG_ADDR, `LSI_ADDR_TL_LO)) thr_d.low[7:0] = pick(REG_ADDR, `LSI_ADDR_TL_LO);
		if (hit(REG_ADDR, `LSI_ADDR_TL_HI)) thr_d.low[15:8] = pick(REG_ADDR, `LSI_ADDR_TL_HI);
		if (hit(REG_ADDR, `LSI_ADDR_TH_LO)) thr_d.high[7:0] = pick(REG_ADDR, `LSI_ADDR_TH_LO);
		if (hit(REG_ADDR, `LSI_ADDR_TH_HI)) thr_d.high[15:8] = pick(REG_ADDR, `LSI_ADDR_TH_HI);
		rdata_d = rdata_q;
		if (REG_RD) begin
			case (REG_ADDR)
				`LSI_ADDR_STATUS: begin
					rdata_d = `LSI_RST_BYTE;
					rdata_d[`LSI_STAT_IRQ_MODE_SELECT_BIT] = irq_q;
					rdata_d[`LSI_STAT_VALID_BIT] = valid_q;
				end
				`LSI_ADDR_TIMING: rdata_d = integration_cycles_field_q;
				// Reserved bits 7 and 5 read back as zero
				`LSI_ADDR_IRQ_MODE_SELECT: rdata_d = {1'b0, ctl_q.halt_on_irq, 1'b0,
					ctl_q.irq_mode_select, ctl_q.persist};
				`LSI_ADDR_TL_LO: rdata_d = thr_q.low[7:0];
				`LSI_ADDR_TL_HI: rdata_d = thr_q.low[15:8];
				`LSI_ADDR_TH_LO: rdata_d = thr_q.high[7:0];
				`LSI_ADDR_TH_HI: rdata_d = thr_q.high[15:8];
				default: rdata_d = `LSI_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			integration_cycles_field_q <= `LSI_RST_BYTE;
			ctl_q <= '0;
			thr_q <= '0;
			rdata_q <= `LSI_RST_BYTE;
		end else begin
			integration_cycles_field_q <= integration_cycles_field_d;
			ctl_q <= ctl_d;
			thr_q <= thr_d;
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Integration timer and interrupt

	lsi_pkg::lsi_state_t state_q, state_d;
	logic [18:0] tick_q, tick_d;
	logic [8:0] per_q, per_d;
	logic [8:0] per_need;
	logic done_q, done_d;
	logic [3:0] miss_q, miss_d;
	logic [3:0] miss_nxt;
	logic out_rng, fire, clr, oe_q, oe_d;

	// Two's complement: 0xFF is one period, 0x01 is 255 periods
	assign per_need = 9'h100 - {1'b0, integration_cycles_field_q};
	assign out_rng = (CH0_DATA <= thr_q.low) || (CH0_DATA > thr_q.high);
	assign clr = CMD_STB && (CMD_TXN == `LSI_CMD_CLEAR);
	assign miss_nxt = !out_rng ? 4'h0 : ((miss_q == 4'hF) ? miss_q : miss_q + 4'h1);
	assign fire = (ctl_q.persist == 4'h0) ||
		(out_rng && ((ctl_q.persist == 4'h1) || (miss_nxt >= ctl_q.persist)));

	always_comb begin
		state_d = state_q;
		tick_d = tick_q;
		per_d = per_q;
		done_d = 1'b0;
		miss_d = miss_q;
		valid_d = valid_q;
		case (state_q)
			lsi_pkg::ST_IDLE: begin
				tick_d = '0;
				per_d = '0;
				// A zero field means manual timing, which this timer leaves alone
				if (ADC_EN && (integration_cycles_field_q != `LSI_RST_BYTE)) state_d = lsi_pkg::ST_INTEG;
			end
			lsi_pkg::ST_INTEG: begin
				if (!ADC_EN) begin
					state_d = lsi_pkg::ST_IDLE;
				end else if (ctl_q.halt_on_irq && irq_q) begin
					state_d = lsi_pkg::ST_HALT;
				end else if (tick_q == 19'(PERIOD_CYC - 1)) begin
					tick_d = '0;
					if (per_q + 9'h001 == per_need) begin
						per_d = '0;
						done_d = 1'b1;
						valid_d = 1'b1;
						miss_d = miss_nxt;
					end else begin
						per_d = per_q + 9'h001;
					end
				end else begin
					tick_d = tick_q + 19'h00001;
				end
			end
			// Only a drop of the enable leaves a halt, so a clear alone cannot restart
			lsi_pkg::ST_HALT: if (!ADC_EN) state_d = lsi_pkg::ST_IDLE;
			default: state_d = lsi_pkg::ST_IDLE;
		endcase
		// Set wins over a clear landing in the same cycle
		irq_d = (done_d && fire && ctl_q.irq_mode_select) || (irq_q && !clr);
		oe_d = !(irq_d && ctl_q.irq_mode_select);
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_q <= lsi_pkg::ST_IDLE;
			tick_q <= '0;
			per_q <= '0;
			done_q <= 1'b0;
			miss_q <= 4'h0;
			valid_q <= 1'b0;
			irq_q <= 1'b0;
			oe_q <= 1'b1;
		end else begin
			state_q <= state_d;
			tick_q <= tick_d;
			per_q <= per_d;
			done_q <= done_d;
			miss_q <= miss_d;
			valid_q <= valid_d;
			irq_q <= irq_d;
			oe_q <= oe_d;
		end
	end

	assign INTEG_ACTIVE = state_q[1];
	assign INTEG_DONE = done_q;
	assign INT_N_O = 1'b0 & oe_q;
	assign INT_N_OE = oe_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_halted;
		ctl_q.halt_on_irq && irq_q && state_q == lsi_pkg::ST_INTEG && ADC_EN;
	endsequence

	a_pin_low_irq: assert property (!INT_N_OE |-> irq_q && $past(ctl_q.irq_mode_select))
		else $error("Pin driven without an active enabled interrupt");
	a_mode_off_rel: assert property (!ctl_q.irq_mode_select |=> INT_N_OE)
		else $error("Pin driven with interrupt mode off");
	a_hold_till_clr: assert property (irq_q && !clr |=> irq_q)
		else $error("Interrupt dropped without clear command");
	a_set_source: assert property (!irq_q && $past(!irq_q) |-> !INT_N_OE == 1'b0)
		else $error("Pin active without interrupt");
	a_rise_on_done: assert property ($rose(irq_q) |-> done_q && $past(ctl_q.irq_mode_select))
		else $error("Interrupt rose outside a conversion end");
	a_halt_stops: assert property (s_halted |=> state_q == lsi_pkg::ST_HALT ##1 !INTEG_DONE)
		else $error("Integration kept running after interrupt");
	a_persist_every: assert property (done_d && ctl_q.persist == 4'h0 &&
		ctl_q.irq_mode_select |=> irq_q)
		else $error("Persist 0 missed a conversion");
	a_inrange_quiet: assert property (done_d && !out_rng && ctl_q.persist != 4'h0 && !irq_q
		&& !clr |=> !irq_q)
		else $error("In-range value raised interrupt");
	a_done_spacing: assert property ($rose(INTEG_DONE) |=> !INTEG_DONE)
		else $error("Conversion end longer than one cycle");

endmodule : lsi_irq
`default_nettype wire

// ### core/lsi_cfg.svh
`ifndef LSI_CFG_SVH
`define LSI_CFG_SVH

`define LSI_ADDR_STATUS 8'h00
`define LSI_ADDR_TIMING 8'h01
`define LSI_ADDR_IRQ_MODE_SELECT 8'h02
`define LSI_ADDR_TL_LO 8'h03
`define LSI_ADDR_TL_HI 8'h04
`define LSI_ADDR_TH_LO 8'h05
`define LSI_ADDR_TH_HI 8'h06

`define LSI_HALT_BIT 6
`define LSI_MODE_BIT 4
`define LSI_PERSIST_MSB 3
`define LSI_STAT_IRQ_MODE_SELECT_BIT 5
`define LSI_STAT_VALID_BIT 4

`define LSI_RST_BYTE 8'h00
`define LSI_RST_WORD 16'h0000
`define LSI_CMD_CLEAR 2'h3

`define LSI_PERIOD_NS 2700000
`define LSI_CLK_NS 10
`define LSI_PERIOD_CYC (`LSI_PERIOD_NS / `LSI_CLK_NS)

`endif

// ### core/lsi_pkg.sv
package lsi_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_INTEG = 3'h2,
		ST_HALT = 3'h4
	} lsi_state_t;

	typedef struct packed {
		logic halt_on_irq;
		logic irq_mode_select;
		logic [3:0] persist;
	} lsi_ctl_t;

	typedef struct packed {
		logic [15:0] low;
		logic [15:0] high;
	} lsi_thresh_t;

endpackage : lsi_pkg

// ### bench/lsi_host.sv
`timescale 1ns/1ps
`default_nettype none
module lsi_host (
	input wire logic CLK,
	output logic WR,
	output logic WORD,
	output logic RD,
	output logic [7:0] ADDR,
	output logic [15:0] WDATA,
	output logic STB,
	output logic [1:0] TXN
);
	initial {WR, WORD, RD, ADDR, WDATA, STB, TXN} = '0;
	////////////////////////////////////////
	// Paired bytes go as one word when w is set; commands travel only on STB and TXN
	task automatic put(input logic [7:0] a, input logic [15:0] d, input logic w);
		@(posedge CLK) #1;
		{WR, WORD, ADDR, WDATA} = {1'b1, w, a, d};
		@(posedge CLK) #1;
		WR = 1'b0;
	endtask : put
	task automatic get(input logic [7:0] a);
		@(posedge CLK) #1;
		{RD, ADDR} = {1'b1, a};
		@(posedge CLK) #1;
		RD = 1'b0;
	endtask : get
	task automatic cmd(input logic [1:0] t);
		@(posedge CLK) #1;
		{STB, TXN} = {1'b1, t};
		@(posedge CLK) #1;
		STB = 1'b0;
	endtask : cmd
endmodule : lsi_host
`default_nettype wire

// ### bench/light_sensor_interrupt_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module light_sensor_interrupt_logic_test;
	logic CLK = 0, RST_N = 0, ADC_EN = 0, rd_q = 0;
	logic [15:0] CH0_DATA = 16'h0000;
	logic wr, wd, rd, stb, act, done, pin_o, pin_oe;
	logic [7:0] ad, rdata;
	logic [15:0] wdat;
	logic [1:0] txn;
	logic [7:0] exp_q[$];
	logic [15:0] vals[5] = '{16'h0100, 16'h0101, 16'h0200, 16'h0201, 16'h0000};
	logic [4:0] hit = 5'h06;
	int bad_count = 0, checked = 0, cyc = 0;
	initial forever #5 CLK = ~CLK;
	lsi_host host_u (.CLK(CLK), .WR(wr), .WORD(wd), .RD(rd), .ADDR(ad), .WDATA(wdat),
		.STB(stb), .TXN(txn));
	lsi_irq #(.PERIOD_CYC(4)) dut_u (.CLK(CLK), .RST_N(RST_N), .REG_WR(wr), .REG_WORD(wd),
		.REG_RD(rd), .REG_ADDR(ad), .REG_WDATA(wdat), .REG_RDATA(rdata), .CMD_STB(stb),
		.CMD_TXN(txn), .ADC_EN(ADC_EN), .CH0_DATA(CH0_DATA), .INTEG_ACTIVE(act),
		.INTEG_DONE(done), .INT_N_O(pin_o), .INT_N_OE(pin_oe));
	////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.get(a);
	endtask : rd_exp
	// Counts integration ends (done pulses); the global cycle ceiling bounds every wait
	task automatic dones(input int n);
		repeat (n) @(posedge CLK iff done);
		#1;
	endtask : dones
	////////////////////////////////////////
	always @(posedge CLK) begin
		if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
		rd_q <= rd;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(32'h26D4));
		repeat (20) @(posedge CLK);
		#1 RST_N = 1;
		rd_exp(8'h02, 8'h00);
		rd_exp(8'h07, 8'h00);
		host_u.put(8'h02, 16'h005F, 0);
		rd_exp(8'h02, 8'h5F);
		host_u.put(8'h03, 16'h0100, 1);
		host_u.put(8'h05, 16'h0200, 1);
		// Timing and control go as one word: FF lands in timing at 0x01, 0x11 in control at 0x02
		host_u.put(8'h01, 16'h11FF, 1);
		rd_exp(8'h04, 8'h01);
		vals[4] = 16'h0201 + 16'($urandom_range(0, 16'hFDFE));
		ADC_EN = 1;
		for (int i = 0; i < 5; i++) begin
			CH0_DATA = vals[i];
			host_u.cmd(2'h3);
			dones(2);
			chk("pin_oe", 16'(hit[i]), 16'(pin_oe));
		end
		chk("pin_o", 16'h0000, 16'(pin_o));
		CH0_DATA = 16'h0150;
		host_u.put(8'h02, 16'h0013, 0);
		host_u.cmd(2'h3);
		dones(1);
		CH0_DATA = 16'h0050;
		dones(2);
		chk("persist2", 16'h0001, 16'(pin_oe));
		dones(1);
		chk("persist3", 16'h0000, 16'(pin_oe));
		CH0_DATA = 16'h0150;
		dones(1);
		chk("held", 16'h0000, 16'(pin_oe));
		rd_exp(8'h00, 8'h30);
		for (int t = 0; t < 3; t++) begin
			host_u.cmd(2'(t));
			chk("noclr", 16'h0000, 16'(pin_oe));
		end
		host_u.cmd(2'h3);
		chk("clr", 16'h0001, 16'(pin_oe));
		host_u.put(8'h02, 16'h0000, 0);
		CH0_DATA = 16'h0050;
		dones(2);
		chk("mode0", 16'h0001, 16'(pin_oe));
		CH0_DATA = 16'h0150;
		host_u.put(8'h02, 16'h0010, 0);
		dones(2);
		chk("every", 16'h0000, 16'(pin_oe));
		host_u.put(8'h02, 16'h0050, 0);
		repeat (12) @(posedge CLK);
		#1;
		chk("halt", 16'h0000, 16'(act));
		ADC_EN = 0;
		host_u.cmd(2'h3);
		ADC_EN = 1;
		dones(1);
		chk("resume", 16'h0000, 16'(pin_oe));
		wrap_up();
	end
endmodule : light_sensor_interrupt_logic_test
`default_nettype wire
